// ---- hw/dgcf_defs.vh ----
// Constants for the DMA global control and transfer sequencer
`ifndef DGCF_DEFS_VH
`define DGCF_DEFS_VH

// ==========================================================
// Register addresses (4-bit word index on the register port)
`define DGCF_ADDR_GLOBAL 4'h8
`define DGCF_SEL_CTRL 1'b0
`define DGCF_SEL_COUNT 1'b1

// ==========================================================
// Global operation register fields
`define DGCF_G_RESET 16'h0000
`define DGCF_G_MASTER_EN 0
`define DGCF_G_NMI_FLAG 1
`define DGCF_G_ADDR_ERR 2
`define DGCF_G_PR_LO 8
`define DGCF_G_PR_HI 9

// Priority modes
`define DGCF_PR_FIX0 2'h0
`define DGCF_PR_FIX1 2'h1
`define DGCF_PR_RR 2'h2
`define DGCF_PR_RRX 2'h3

// Orders, two bits per slot, slot 0 is served first
`define DGCF_ORD_FIX0 8'h6C
`define DGCF_ORD_FIX1 8'h2D
`define DGCF_ORD_RRX 8'h1B

// ==========================================================
// Channel control register fields
`define DGCF_C_RESET 16'h0000
`define DGCF_C_CH_EN 0
`define DGCF_C_END_FLAG 1
`define DGCF_C_END_IRQ_EN 2
`define DGCF_C_TS 3
`define DGCF_C_TM 4
`define DGCF_C_EDGE_SEL 5
`define DGCF_C_RM_LO 6
`define DGCF_C_RM_HI 7
`define DGCF_C_SA 8
`define DGCF_C_WMASK 16'h01FD

// Request modes
`define DGCF_RM_AUTO 2'h0
`define DGCF_RM_EXT 2'h1
`define DGCF_RM_MOD 2'h2

// ==========================================================
// Sequencer states, one-hot
`define DGCF_ST_IDLE 2'h1
`define DGCF_ST_BUSY 2'h2

`endif

// ---- hw/dgcf_top.v ----
// DMA global control register, channel arbitration and unit sequencing
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dgcf_defs.vh"

// Overview of operation
// - Global register 16 bits, reset/standby clear
// - Reserved global bits read zero
// - Priority field picks channel among pending
// - Fixed orders 0,3,2,1 and 1,3,2,0
// - Mode 10 round-robin from 0,3,2,1
// - Mode 11 round-robin from 3,2,1,0
// - Controller address error sets flag
// - NMI event sets flag
// - Either flag blocks every channel start
// - Flags clear by read one, write zero
// - Enable needs both enables, no flags
// - Master enable low aborts all channels
// - Each request moves one unit, count-1
// - Auto mode starts without any request
// - Count zero ends, interrupt if enabled
// - Address error or NMI aborts transfers
// - Channel or master enable low aborts
// - Single/dual, burst/steal, three request sources
// - Normal end sets transfer end flag
// - Aborted end leaves end flag clear
// - Detect select: low level or falling edge
module dgcf_top #(
    parameter COUNT_W = 16
) (
    input wire clk_sys,
    input wire srst,
    input wire clk_en,
    input wire standby,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire nmi_in,
    input wire [3:0] ext_req_n,
    input wire [3:0] module_req,
    output reg xfer_req,
    output reg [1:0] xfer_ch,
    output reg xfer_single,
    output reg xfer_word,
    output reg xfer_burst,
    input wire xfer_done,
    input wire xfer_addr_err,
    output wire [3:0] end_irq
);

    // ======================================================
    // Declarations
    wire clr;
    reg master_transfer_enable;
    reg nmi_abort_flag;
    reg address_error_flag;
    reg nmi_armed;
    reg err_armed;
    reg [1:0] prio;
    reg [7:0] rr_order;
    reg [7:0] next_rr;
    reg [7:0] order_cur;
    reg nmi_s1;
    reg nmi_s2;
    reg nmi_s3;
    wire nmi_event;
    wire wr_g;
    wire rd_g;
    reg [1:0] state;
    reg [1:0] cur_ch;
    reg burst_hold;
    wire [3:0] ch_ok;
    wire [3:0] pend;
    wire [3:0] burst_sel;
    wire [3:0] single_sel;
    wire [3:0] word_sel;
    wire [63:0] ctrl_all;
    wire [4*COUNT_W-1:0] count_all;
    reg [1:0] winner;
    reg found;
    reg grant;
    reg [1:0] grant_ch;
    wire unit_done;
    wire unit_abort;
    integer k;
    integer n;

    assign clr = srst | standby;

    // ======================================================
    // NMI pin synchroniser and rising edge
    assign nmi_event = nmi_s2 & ~nmi_s3;

    // ======================================================
    // Global operation register
    assign wr_g = reg_wr & (reg_addr == `DGCF_ADDR_GLOBAL);
    assign rd_g = reg_rd & (reg_addr == `DGCF_ADDR_GLOBAL);

    always @(posedge clk_sys) begin
        if (clr) begin
            master_transfer_enable <= 1'b0;
            nmi_abort_flag <= 1'b0;
            address_error_flag <= 1'b0;
            nmi_armed <= 1'b0;
            err_armed <= 1'b0;
            prio <= `DGCF_PR_FIX0;
            rr_order <= `DGCF_ORD_FIX0;
            nmi_s1 <= 1'b0;
            nmi_s2 <= 1'b0;
            nmi_s3 <= 1'b0;
        end else if (clk_en) begin
            nmi_s1 <= nmi_in;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
            if (wr_g) begin
                master_transfer_enable <= reg_wdata[`DGCF_G_MASTER_EN];
                prio <= reg_wdata[`DGCF_G_PR_HI:`DGCF_G_PR_LO];
            end
            // Arming only on a read that actually returned one
            if (rd_g && address_error_flag) begin
                err_armed <= 1'b1;
            end
            if (rd_g && nmi_abort_flag) begin
                nmi_armed <= 1'b1;
            end
            if (wr_g && err_armed && !reg_wdata[`DGCF_G_ADDR_ERR]) begin
                address_error_flag <= 1'b0;
                err_armed <= 1'b0;
            end
            if (wr_g && nmi_armed && !reg_wdata[`DGCF_G_NMI_FLAG]) begin
                nmi_abort_flag <= 1'b0;
                nmi_armed <= 1'b0;
            end
            // Hardware set comes last so it beats a clear
            if (xfer_addr_err && state == `DGCF_ST_BUSY) begin
                address_error_flag <= 1'b1;
            end
            if (nmi_event) begin
                nmi_abort_flag <= 1'b1;
            end
            // Entering a round-robin mode restarts its order
            if (wr_g && reg_wdata[`DGCF_G_PR_HI:`DGCF_G_PR_LO] != prio
                && reg_wdata[`DGCF_G_PR_HI]) begin
                if (reg_wdata[`DGCF_G_PR_LO]) begin
                    rr_order <= `DGCF_ORD_RRX;
                end else begin
                    rr_order <= `DGCF_ORD_FIX0;
                end
            end else if (grant && prio[1]) begin
                rr_order <= next_rr;
            end
        end
    end

    // ======================================================
    // Per-channel control, count, request detection
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
            localparam [1:0] CH_ID = gi;
            reg [15:0] ctrl;
            reg [COUNT_W-1:0] count;
            reg end_armed;
            reg ext_s1;
            reg ext_s2;
            reg ext_s3;
            reg edge_pend;
            reg req_seen;
            wire wr_c;
            wire wr_n;
            wire rd_c;
            wire [1:0] rmode;
            wire mine;

            assign wr_c = reg_wr && reg_addr == {1'b0, CH_ID, `DGCF_SEL_CTRL};
            assign wr_n = reg_wr && reg_addr == {1'b0, CH_ID, `DGCF_SEL_COUNT};
            assign rd_c = reg_rd && reg_addr == {1'b0, CH_ID, `DGCF_SEL_CTRL};
            assign rmode = ctrl[`DGCF_C_RM_HI:`DGCF_C_RM_LO];
            assign mine = cur_ch == CH_ID;

            // A zero count cannot start, so a unit never wraps the count
            assign ch_ok[gi] = ctrl[`DGCF_C_CH_EN] & master_transfer_enable
                & ~ctrl[`DGCF_C_END_FLAG] & ~nmi_abort_flag
                & ~address_error_flag & (count != {COUNT_W{1'b0}});

            always @* begin
                if (rmode == `DGCF_RM_AUTO) begin
                    req_seen = 1'b1;
                end else if (rmode == `DGCF_RM_EXT) begin
                    req_seen = ctrl[`DGCF_C_EDGE_SEL] ? edge_pend
                        : ~ext_s2;
                end else if (rmode == `DGCF_RM_MOD) begin
                    req_seen = module_req[gi];
                end else begin
                    req_seen = 1'b0;
                end
            end

            assign pend[gi] = ch_ok[gi] & req_seen;
            assign burst_sel[gi] = ctrl[`DGCF_C_TM];
            assign single_sel[gi] = ctrl[`DGCF_C_SA];
            assign word_sel[gi] = ctrl[`DGCF_C_TS];
            assign ctrl_all[16*gi +: 16] = ctrl;
            assign count_all[COUNT_W*gi +: COUNT_W] = count;
            assign end_irq[gi] = ctrl[`DGCF_C_END_FLAG]
                & ctrl[`DGCF_C_END_IRQ_EN];

            always @(posedge clk_sys) begin
                if (clr) begin
                    ctrl <= `DGCF_C_RESET;
                    count <= {COUNT_W{1'b0}};
                    end_armed <= 1'b0;
                    ext_s1 <= 1'b1;
                    ext_s2 <= 1'b1;
                    ext_s3 <= 1'b1;
                    edge_pend <= 1'b0;
                end else if (clk_en) begin
                    ext_s1 <= ext_req_n[gi];
                    ext_s2 <= ext_s1;
                    ext_s3 <= ext_s2;
                    if (grant && grant_ch == CH_ID) begin
                        edge_pend <= 1'b0;
                    end
                    // Edges are remembered until a unit consumes one
                    if (ctrl[`DGCF_C_EDGE_SEL] && ext_s3 && !ext_s2) begin
                        edge_pend <= 1'b1;
                    end
                    if (wr_c) begin
                        ctrl <= (reg_wdata & `DGCF_C_WMASK)
                            | (ctrl & ~`DGCF_C_WMASK);
                    end
                    if (rd_c && ctrl[`DGCF_C_END_FLAG]) begin
                        end_armed <= 1'b1;
                    end
                    if (wr_c && end_armed && !reg_wdata[`DGCF_C_END_FLAG]) begin
                        ctrl[`DGCF_C_END_FLAG] <= 1'b0;
                        end_armed <= 1'b0;
                    end
                    if (wr_n) begin
                        count <= reg_wdata[COUNT_W-1:0];
                    end
                    if (unit_done && mine) begin
                        count <= count - 1'b1;
                        if (count == {{(COUNT_W-1){1'b0}}, 1'b1}) begin
                            ctrl[`DGCF_C_END_FLAG] <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // ======================================================
    // Arbitration
    always @* begin
        if (prio == `DGCF_PR_FIX0) begin
            order_cur = `DGCF_ORD_FIX0;
        end else if (prio == `DGCF_PR_FIX1) begin
            order_cur = `DGCF_ORD_FIX1;
        end else begin
            order_cur = rr_order;
        end
        winner = 2'h0;
        found = 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            if (!found && pend[order_cur[2*k +: 2]]) begin
                winner = order_cur[2*k +: 2];
                found = 1'b1;
            end
        end
    end

    // Served channel goes last, the rest keep their order
    always @* begin
        next_rr = 8'h00;
        n = 0;
        for (k = 0; k < 4; k = k + 1) begin
            if (rr_order[2*k +: 2] != grant_ch) begin
                next_rr[2*n +: 2] = rr_order[2*k +: 2];
                n = n + 1;
            end
        end
        next_rr[7:6] = grant_ch;
    end

    // Burst keeps the bus on the same channel while it still asks
    always @* begin
        grant = 1'b0;
        grant_ch = winner;
        if (state == `DGCF_ST_IDLE) begin
            if (burst_hold && pend[cur_ch]) begin
                grant = 1'b1;
                grant_ch = cur_ch;
            end else begin
                grant = found;
            end
        end
    end

    // ======================================================
    // Unit sequencer
    // Abort wins over a completion in the same cycle, so an
    // aborted channel never gets its end flag
    assign unit_abort = (state == `DGCF_ST_BUSY) & (~ch_ok[cur_ch]
        | nmi_event | xfer_addr_err);
    assign unit_done = (state == `DGCF_ST_BUSY) & xfer_done & ~unit_abort;

    always @(posedge clk_sys) begin
        if (clr) begin
            state <= `DGCF_ST_IDLE;
            cur_ch <= 2'h0;
            burst_hold <= 1'b0;
            xfer_req <= 1'b0;
            xfer_ch <= 2'h0;
            xfer_single <= 1'b0;
            xfer_word <= 1'b0;
            xfer_burst <= 1'b0;
        end else if (clk_en) begin
            case (state)
                `DGCF_ST_IDLE: begin
                    burst_hold <= 1'b0;
                    if (grant) begin
                        state <= `DGCF_ST_BUSY;
                        cur_ch <= grant_ch;
                        xfer_req <= 1'b1;
                        xfer_ch <= grant_ch;
                        xfer_single <= single_sel[grant_ch];
                        xfer_word <= word_sel[grant_ch];
                        xfer_burst <= burst_sel[grant_ch];
                    end
                end
                `DGCF_ST_BUSY: begin
                    if (unit_abort) begin
                        state <= `DGCF_ST_IDLE;
                        xfer_req <= 1'b0;
                    end else if (unit_done) begin
                        state <= `DGCF_ST_IDLE;
                        xfer_req <= 1'b0;
                        burst_hold <= burst_sel[cur_ch];
                    end
                end
                default: begin
                    state <= `DGCF_ST_IDLE;
                    xfer_req <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================
    // Register read port, data valid in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (clr) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            reg_rdata <= 16'h0000;
            if (!reg_rd) begin
                reg_rdata <= 16'h0000;
            end else if (reg_addr == `DGCF_ADDR_GLOBAL) begin
                reg_rdata <= {6'h00, prio, 5'h00, address_error_flag,
                    nmi_abort_flag, master_transfer_enable};
            end else if (reg_addr[3] == 1'b0 &&
                reg_addr[0] == `DGCF_SEL_CTRL) begin
                reg_rdata <= ctrl_all[16*reg_addr[2:1] +: 16];
            end else if (reg_addr[3] == 1'b0) begin
                reg_rdata <= {{(16-COUNT_W){1'b0}},
                    count_all[COUNT_W*reg_addr[2:1] +: COUNT_W]};
            end
        end
    end

endmodule
`default_nettype wire

// ---- verification/dgcf_top_props.sv ----
// Port-level checker for the DMA global control block
`timescale 1ns/10ps
`default_nettype none
`include "dgcf_defs.vh"
module dgcf_props (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic standby,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic xfer_req,
    input wire logic [1:0] xfer_ch,
    input wire logic xfer_done,
    input wire logic xfer_addr_err,
    input wire logic [3:0] end_irq,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata
);
    // ==========================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst || standby);
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    AST_RD_RSV: assert property ($past(reg_rd) &&
        $past(reg_addr) == `DGCF_ADDR_GLOBAL |->
        reg_rdata[15:10] == 6'h00 && reg_rdata[7:3] == 5'h00)
        else $error("reserved global bits read nonzero");
    AST_RD_UNMAP: assert property ($past(reg_rd) &&
        $past(reg_addr) > 4'h8 |-> reg_rdata == 16'h0000)
        else $error("unmapped read nonzero");
    AST_DONE_DROP: assert property (xfer_req && xfer_done |=> !xfer_req)
        else $error("unit request held after done");
    AST_CH_HOLD: assert property (xfer_req && $past(xfer_req) |-> $stable(xfer_ch))
        else $error("channel changed during a unit");
    AST_IRQ_CAUSE: assert property ($rose(|end_irq) |->
        $past(xfer_done) && !$past(xfer_addr_err))
        else $error("end interrupt without a normal unit end");
    AST_ERR_ABORT: assert property (xfer_req && xfer_addr_err |=> !xfer_req)
        else $error("unit not aborted on address error");
    AST_ERR_HOLD: assert property (xfer_req && xfer_addr_err |=> !xfer_req [*3])
        else $error("unit started with address error flag set");
    AST_MASTER_OFF: assert property (reg_wr &&
        reg_addr == `DGCF_ADDR_GLOBAL && !reg_wdata[0] |-> ##2 !xfer_req)
        else $error("unit not aborted by master enable clear");
endmodule
`default_nettype wire

// ---- verification/dgcf_bus_model.sv ----
// Bus-side model that finishes each transfer unit after a set latency
`timescale 1ns/10ps
`default_nettype none
module dgcf_bus_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic xfer_req,
    input wire logic [3:0] lat,
    input wire logic err_next,
    output logic xfer_done,
    output logic xfer_addr_err
);
    logic [3:0] cnt;
    logic sent;
    // ==========================================
    // One answer per unit, never repeated while the request stands
    always @(posedge clk_sys) begin
        xfer_done <= 1'b0;
        xfer_addr_err <= 1'b0;
        if (srst || !xfer_req) begin
            cnt <= 4'h0;
            sent <= 1'b0;
        end else if (!sent && cnt == lat) begin
            sent <= 1'b1;
            xfer_addr_err <= err_next;
            xfer_done <= !err_next;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ---- verification/test_dma_global_control_flow.sv ----
// Self-checking bench for the DMA global control block
`timescale 1ns/10ps
`default_nettype none
`include "dgcf_defs.vh"
module test_dma_global_control_flow;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic standby = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nmi_in = 1'b0;
    logic [3:0] ext_req_n = 4'hF;
    logic [3:0] module_req = 4'h0;
    logic [3:0] lat = 4'h2;
    logic err_next = 1'b0;
    wire [15:0] reg_rdata;
    wire xfer_req, xfer_single, xfer_word, xfer_burst;
    wire xfer_done, xfer_addr_err;
    wire [1:0] xfer_ch;
    wire [3:0] end_irq;
    int n_mismatch = 0;
    int comparisons = 0;
    int k;
    logic [15:0] ord;
    logic [15:0] exp_ord [4] = '{16'h0FA5, 16'h5FA0, 16'h3939, 16'hE4E4};
    always #10 clk_sys = ~clk_sys;

    dgcf_top dut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
        .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nmi_in(nmi_in), .ext_req_n(ext_req_n), .module_req(module_req),
        .xfer_req(xfer_req), .xfer_ch(xfer_ch), .xfer_single(xfer_single),
        .xfer_word(xfer_word), .xfer_burst(xfer_burst),
        .xfer_done(xfer_done), .xfer_addr_err(xfer_addr_err),
        .end_irq(end_irq));
    dgcf_bus_model bus (.clk_sys(clk_sys), .srst(srst), .xfer_req(xfer_req),
        .lat(lat), .err_next(err_next), .xfer_done(xfer_done),
        .xfer_addr_err(xfer_addr_err));

    // ==========================================
    // Register port and check helpers
    task automatic final_report;
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // Bounded so a stuck sequencer ends the run instead of hanging it
    task automatic wait_req(input logic v);
        int i;
        for (i = 0; i < 300 && xfer_req !== v; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (xfer_req !== v) begin
            n_mismatch++;
            final_report;
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        rd(`DGCF_ADDR_GLOBAL, 16'h0000);
        wr(`DGCF_ADDR_GLOBAL, 16'hFFFE);
        rd(`DGCF_ADDR_GLOBAL, 16'h0300);
        rd(4'hF, 16'h0000);
        wr(4'h1, 16'h0002);
        wr(4'h0, 16'h0005);
        wr(`DGCF_ADDR_GLOBAL, 16'h0001);
        for (k = 0; k < 2; k++) begin
            wait_req(1'b1);
            chk({11'h0, xfer_single, xfer_word, xfer_burst, xfer_ch}, 16'h0000);
            wait_req(1'b0);
        end
        repeat (3) @(posedge clk_sys);
        #1;
        chk({12'h000, end_irq}, 16'h0001);
        rd(4'h0, 16'h0007);
        rd(4'h1, 16'h0000);
        // All four channels pending at once with two units each, so that
        // round-robin rotation differs from a fixed order
        for (k = 0; k < 4; k++) begin
            for (int c = 0; c < 4; c++) begin
                wr({1'b0, c[1:0], 1'b1}, 16'h0002);
                wr({1'b0, c[1:0], 1'b0}, 16'h0081);
            end
            wr(`DGCF_ADDR_GLOBAL, {6'h00, k[1:0], 8'h01});
            module_req <= 4'hF;
            for (int u = 0; u < 8; u++) begin
                wait_req(1'b1);
                ord = {ord[13:0], xfer_ch};
                wait_req(1'b0);
            end
            module_req <= 4'h0;
            chk(ord, exp_ord[k]);
            for (int c = 0; c < 4; c++)
                rd({1'b0, c[1:0], 1'b0}, 16'h0083);
        end
        wr(4'h1, 16'h0003);
        wr(4'h0, 16'h0001);
        err_next <= 1'b1;
        wr(`DGCF_ADDR_GLOBAL, 16'h0001);
        wait_req(1'b1);
        wait_req(1'b0);
        err_next <= 1'b0;
        rd(`DGCF_ADDR_GLOBAL, 16'h0005);
        rd(4'h1, 16'h0003);
        rd(4'h0, 16'h0001);
        chk({15'h0, xfer_req}, 16'h0000);
        lat <= 4'hF;
        wr(`DGCF_ADDR_GLOBAL, 16'h0001);
        wait_req(1'b1);
        wr(`DGCF_ADDR_GLOBAL, 16'h0000);
        wait_req(1'b0);
        rd(4'h1, 16'h0003);
        rd(4'h0, 16'h0001);
        wr(`DGCF_ADDR_GLOBAL, 16'h0001);
        wait_req(1'b1);
        nmi_in <= 1'b1;
        wait_req(1'b0);
        rd(`DGCF_ADDR_GLOBAL, 16'h0003);
        rd(4'h1, 16'h0003);
        nmi_in <= 1'b0;
        // External level request on channel 1 with every unit attribute
        wr(4'h0, 16'h0000);
        wr(4'h3, 16'h0001);
        wr(4'h2, 16'h0159);
        wr(`DGCF_ADDR_GLOBAL, 16'h0001);
        lat <= 4'h2;
        repeat (8) @(posedge clk_sys);
        #1;
        chk({15'h0, xfer_req}, 16'h0000);
        ext_req_n <= 4'hD;
        wait_req(1'b1);
        chk({11'h0, xfer_single, xfer_word, xfer_burst, xfer_ch}, 16'h001D);
        ext_req_n <= 4'hF;
        wait_req(1'b0);
        rd(4'h2, 16'h015B);
        // Falling-edge detect: a held low level gives one unit only
        wr(4'h3, 16'h0002);
        wr(4'h2, 16'h0061);
        ext_req_n <= 4'hD;
        wait_req(1'b1);
        wait_req(1'b0);
        repeat (8) @(posedge clk_sys);
        ext_req_n <= 4'hF;
        rd(4'h3, 16'h0001);
        // Clock enable low must swallow a register write
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(`DGCF_ADDR_GLOBAL, 16'h0100);
        clk_en <= 1'b1;
        rd(`DGCF_ADDR_GLOBAL, 16'h0001);
        @(posedge clk_sys);
        standby <= 1'b1;
        @(posedge clk_sys);
        standby <= 1'b0;
        rd(`DGCF_ADDR_GLOBAL, 16'h0000);
        rd(4'h2, 16'h0000);
        final_report;
    end
endmodule

bind dgcf_top dgcf_props u_props (.clk_sys(clk_sys), .srst(srst),
    .standby(standby), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .xfer_req(xfer_req), .xfer_ch(xfer_ch),
    .xfer_done(xfer_done), .xfer_addr_err(xfer_addr_err),
    .end_irq(end_irq), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
`default_nettype wire
